// file: core/spirq_defines.vh
// Notes on behaviour
// [RQ1] Priority bit 0 routes request to level one.
// [RQ2] Priority bit 1 routes request to level five.
// [RQ3] Completion request only while its enable set.
// [RQ4] Every finished character sets the completion flag.
// [RQ5] Completion flag setting raises request when enabled.
// [RQ6] Reading receive buffer clears completion flag.
// [RQ7] Completion flag still set: no further requests.
// [RQ8] Port reset bit or device reset clears completion.
// [RQ9] Overrun enable turns on detection and request.
// [RQ10] Completion with unread character sets overrun flag.
// [RQ11] Each overrun flag setting requests when enabled.
// [RQ12] No new overrun request until flag cleared.
// [RQ13] Writing zero to overrun flag clears it.
// [RQ14] Port or device reset also clears overrun.
// [RQ15] Arbitration forwards highest priority request, sets flag.
// [RQ16] Acknowledge needs mask bit set, global mask clear.
// [RQ17] Remaining pending requests served in priority order.
// [RQ18] Acknowledge loads source vector offset into register.
// [RQ19] Serial port vector offset is always 0x05.
// [RQ20] Level one sources, priorities and offsets fixed.
// [RQ21] Level five sources, priorities and offsets fixed.
// [RQ22] Software reads vector register to find source.
// [RQ23] One request per event; early ones are lost.
// [RQ24] Port request is OR of enabled conditions.
`ifndef SPIRQ_DEFINES_VH
`define SPIRQ_DEFINES_VH

// Register byte addresses.
`define SPIRQ_A_CTRL    8'h00
`define SPIRQ_A_STAT    8'h04
`define SPIRQ_A_CHAR    8'h08
`define SPIRQ_A_RXBUF   8'h0C
`define SPIRQ_A_VECT    8'h10
`define SPIRQ_A_IFLAG   8'h14
`define SPIRQ_A_IMASK   8'h18
`define SPIRQ_A_GMASK   8'h1C

// Field positions.
`define SPIRQ_B_TIE     0
`define SPIRQ_B_OIE     4
`define SPIRQ_B_PRIO    6
`define SPIRQ_B_TFLAG   6
`define SPIRQ_B_OFLAG   7
`define SPIRQ_B_SRST    7
`define SPIRQ_B_LV1     0
`define SPIRQ_B_LV5     4

// Source indices, in falling priority order.
`define SPIRQ_S_EXT1    0
`define SPIRQ_S_EXT2    1
`define SPIRQ_S_EXT3    2
`define SPIRQ_S_PORT    3
`define SPIRQ_S_ARX     4
`define SPIRQ_S_ATX     5
`define SPIRQ_S_RT      6
`define SPIRQ_NSRC      7

// Vector offsets.
`define SPIRQ_V_EXT1    16'h0001
`define SPIRQ_V_EXT2    16'h0011
`define SPIRQ_V_EXT3    16'h001F
`define SPIRQ_V_PORT    16'h0005
`define SPIRQ_V_ARX     16'h0006
`define SPIRQ_V_ATX     16'h0007
`define SPIRQ_V_RT      16'h0010

// Reset values and bus answers.
`define SPIRQ_GMASK_RST 1'b1
`define SPIRQ_OKAY      2'b00
`define SPIRQ_SLVERR    2'b10

`endif

// file: core/spirq_route.v
`timescale 1ns/1ps
`include "spirq_defines.vh"

// Serial port interrupt flags, level routing, arbitration and vector load.
// The core side is kept inside the block: flags, masks and acknowledge,
// so one clock and one reset cover the whole request path.
module spirq_route (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire        ce,
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire        char_done,
    input  wire [7:0]  rx_data,
    input  wire        external_pin_irq_one,
    input  wire        external_pin_irq_two,
    input  wire        external_pin_irq_three,
    input  wire        async_receive_irq,
    input  wire        async_transmit_irq,
    input  wire        async_level_five,
    input  wire        realtime_tick_irq,
    output reg         serial_port_irq,
    output reg         core_ack,
    output reg  [1:0]  core_ack_level
);

    // Port control and status bits.
    reg         tie_q;       // Transfer interrupt enable.
    reg         oie_q;       // Overrun interrupt enable.
    reg         prio_q;      // Level select, 1 means level five.
    reg         tflag_q;     // Transfer-complete flag.
    reg         oflag_q;     // Overrun flag.
    reg         srst_q;      // Port software reset bit.
    reg  [7:0]  rxbuf_q;     // Received character.
    reg  [15:0] vect_q;      // Vector offset register.
    reg  [5:0]  ifr_q;       // Core flags, bit n is level n+1.
    reg  [5:0]  imr_q;       // Core mask bits.
    reg         gmask_q;     // Global mask, 1 blocks acknowledges.
    reg  [`SPIRQ_NSRC-1:0] pend_q; // Per-source pending requests.
    reg  [`SPIRQ_NSRC-1:0] lv5_q;  // Per-source level five marks.

    // Bus decode.
    // A write waits for both address and data, so no holding register
    // is needed for a channel that arrives alone.
    wire        wr_go = ce & s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
    wire        rd_go = ce & s_axi_arvalid & ~s_axi_rvalid;
    wire        wr_lo = wr_go & s_axi_wstrb[0];
    wire [7:0]  wd    = s_axi_wdata[7:0];

    // Both write channels are taken together, so neither can be lost.
    assign s_axi_awready = wr_go;
    assign s_axi_wready  = wr_go;
    assign s_axi_arready = rd_go;

    // True for an address that maps to a register.
    function mapped;
        input [7:0] a;
        begin
            mapped = (a[1:0] == 2'b00) && (a <= `SPIRQ_A_GMASK);
        end
    endfunction

    // Address match for one register; the caller adds the channel and the byte lane.
    function wsel;
        input [7:0] a;
        input [7:0] r;
        begin
            wsel = (a == r);
        end
    endfunction

    // Per-register strobes; only the low byte lane carries register bits.
    wire w_ctrl  = wr_lo & wsel(s_axi_awaddr, `SPIRQ_A_CTRL);
    wire w_stat  = wr_lo & wsel(s_axi_awaddr, `SPIRQ_A_STAT);
    wire w_char  = wr_lo & wsel(s_axi_awaddr, `SPIRQ_A_CHAR);
    wire w_ifr   = wr_lo & wsel(s_axi_awaddr, `SPIRQ_A_IFLAG);
    wire w_imr   = wr_lo & wsel(s_axi_awaddr, `SPIRQ_A_IMASK);
    wire w_gmask = wr_lo & wsel(s_axi_awaddr, `SPIRQ_A_GMASK);
    wire r_rxbuf = rd_go & wsel(s_axi_araddr, `SPIRQ_A_RXBUF);

    // A port reset clears flags; it is also held while the bit stays set.
    wire prst = (w_char & wd[`SPIRQ_B_SRST]) | srst_q; // RQ8 RQ14

    // Flag events; a character finishing is seen only on enabled clock.
    // With the overrun enable low, a second character overwrites the
    // buffer silently.
    wire done   = ce & char_done & ~prst;
    wire t_set  = done & ~tflag_q;                     // RQ4
    wire o_set  = done & tflag_q & oie_q & ~oflag_q;   // RQ10 RQ9

    // New request only on a fresh setting of an enabled flag.
    // Requests follow the edge of a flag, not its level, so a flag that
    // stays set never asks the core twice.
    wire port_req = (t_set & tie_q) | (o_set & oie_q); // RQ5 RQ7 RQ11 RQ12 RQ3 RQ24

    // Source requests, one pulse per event.
    // Other sources must already be one-cycle pulses; a held level would
    // keep setting the pending latch and the core flag.
    wire [`SPIRQ_NSRC-1:0] req;
    assign req[`SPIRQ_S_EXT1] = external_pin_irq_one;
    assign req[`SPIRQ_S_EXT2] = external_pin_irq_two;
    assign req[`SPIRQ_S_EXT3] = external_pin_irq_three;
    assign req[`SPIRQ_S_PORT] = port_req;
    assign req[`SPIRQ_S_ARX]  = async_receive_irq;
    assign req[`SPIRQ_S_ATX]  = async_transmit_irq;
    assign req[`SPIRQ_S_RT]   = realtime_tick_irq;

    // Level of each source: the port follows its priority bit.
    // Sources without a level choice are fixed to level one.
    wire [`SPIRQ_NSRC-1:0] lv5_d;
    assign lv5_d[`SPIRQ_S_EXT1] = 1'b0;
    assign lv5_d[`SPIRQ_S_EXT2] = 1'b0;
    assign lv5_d[`SPIRQ_S_EXT3] = 1'b0;
    assign lv5_d[`SPIRQ_S_PORT] = prio_q;              // RQ1 RQ2
    assign lv5_d[`SPIRQ_S_ARX]  = async_level_five;
    assign lv5_d[`SPIRQ_S_ATX]  = async_level_five;
    assign lv5_d[`SPIRQ_S_RT]   = 1'b0;

    // Vector offset of a source index.
    // Unused indices give offset zero, which software treats as spurious.
    function [15:0] voff;
        input [2:0] s;
        begin
            case (s)
                `SPIRQ_S_EXT1: voff = `SPIRQ_V_EXT1;      // RQ20
                `SPIRQ_S_EXT2: voff = `SPIRQ_V_EXT2;
                `SPIRQ_S_EXT3: voff = `SPIRQ_V_EXT3;
                `SPIRQ_S_PORT: voff = `SPIRQ_V_PORT;      // RQ19
                `SPIRQ_S_ARX:  voff = `SPIRQ_V_ARX;       // RQ21
                `SPIRQ_S_ATX:  voff = `SPIRQ_V_ATX;
                `SPIRQ_S_RT:   voff = `SPIRQ_V_RT;
                default:       voff = 16'h0000;
            endcase
        end
    endfunction

    // Pending sources split by level.
    // The level is the one latched with the request, so a later change of
    // the priority bit does not move a request that is already waiting.
    wire [`SPIRQ_NSRC-1:0] p1 = pend_q & ~lv5_q;
    wire [`SPIRQ_NSRC-1:0] p5 = pend_q & lv5_q;

    // Core acknowledge: flagged, unmasked, global mask clear.
    // Level one is looked at first, so it always wins over level five.
    wire [5:0] live  = ifr_q & imr_q;
    wire       ack1  = ce & ~gmask_q & live[`SPIRQ_B_LV1];            // RQ16
    wire       ack5  = ce & ~gmask_q & ~live[`SPIRQ_B_LV1]
                     & live[`SPIRQ_B_LV5];
    wire       ack   = ack1 | ack5;
    wire [`SPIRQ_NSRC-1:0] cand = ack1 ? p1 : p5;

    // Highest-priority pending source on the acknowledged level.
    // The loop runs from the lowest priority up, so the last hit kept
    // is the highest-priority source.
    reg  [2:0] win;
    reg        found;
    integer    i;
    always @* begin
        win   = 3'd0;
        found = 1'b0;
        for (i = `SPIRQ_NSRC - 1; i >= 0; i = i - 1) begin
            if (cand[i]) begin
                win   = i[2:0];                        // RQ15
                found = 1'b1;
            end
        end
    end

    // One-hot of the source served this cycle.
    wire [`SPIRQ_NSRC-1:0] served = (ack & found) ?
        ({{(`SPIRQ_NSRC-1){1'b0}}, 1'b1} << win) : {`SPIRQ_NSRC{1'b0}};

    // Remaining sources of the served level ask again afterwards.
    wire [`SPIRQ_NSRC-1:0] rest = cand & ~served;
    wire again = ack & (|rest);                         // RQ17

    // Pending latches per source; a new event on the served source wins.
    // Keeping a repeat event that meets its own acknowledge costs one
    // extra acknowledge with the same vector, but loses no event.
    genvar g;
    generate
        for (g = 0; g < `SPIRQ_NSRC; g = g + 1) begin : g_src
            always @(posedge aclk) begin
                if (!aresetn) begin
                    pend_q[g] <= 1'b0;
                    lv5_q[g]  <= 1'b0;
                end else if (ce) begin
                    if (req[g]) begin
                        pend_q[g] <= 1'b1;
                        lv5_q[g]  <= lv5_d[g];
                    end else if (served[g]) begin
                        pend_q[g] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    // Requests reaching each core level this cycle.
    // These use the level of this cycle, the same one the latch stores.
    wire hit1 = |(req & ~lv5_d);
    wire hit5 = |(req & lv5_d);

    // Core flags: set wins over clear; the acknowledge clears its bit.
    // Clears are applied before the sets, so a request in the clearing
    // cycle survives the clear.
    reg [5:0] ifr_d;
    always @* begin
        ifr_d = ifr_q;
        if (w_ifr) begin
            ifr_d = ifr_d & ~wd[5:0];
        end
        if (ack1) begin
            ifr_d[`SPIRQ_B_LV1] = 1'b0;
        end
        if (ack5) begin
            ifr_d[`SPIRQ_B_LV5] = 1'b0;
        end
        if (hit1 | (again & ack1)) begin
            ifr_d[`SPIRQ_B_LV1] = 1'b1;                    // RQ15 RQ1
        end
        if (hit5 | (again & ack5)) begin
            ifr_d[`SPIRQ_B_LV5] = 1'b1;                    // RQ2
        end
    end

    // Port control, flags and the receive buffer.
    // While the software reset bit stays set, writes to the control bits
    // are dropped as well.
    always @(posedge aclk) begin
        if (!aresetn) begin
            tie_q   <= 1'b0;
            oie_q   <= 1'b0;
            prio_q  <= 1'b0;
            tflag_q <= 1'b0;                               // RQ8
            oflag_q <= 1'b0;                               // RQ14
            srst_q  <= 1'b0;
            rxbuf_q <= 8'h00;
        end else if (ce) begin
            if (w_char) begin
                srst_q <= wd[`SPIRQ_B_SRST];
            end
            if (prst) begin
                // Port reset drops the setup, so software must redo it.
                tie_q   <= 1'b0;
                oie_q   <= 1'b0;
                prio_q  <= 1'b0;
                tflag_q <= 1'b0;                           // RQ8
                oflag_q <= 1'b0;                           // RQ14
            end else begin
                if (w_ctrl) begin
                    tie_q  <= wd[`SPIRQ_B_TIE];
                    oie_q  <= wd[`SPIRQ_B_OIE];            // RQ9
                    prio_q <= wd[`SPIRQ_B_PRIO];
                end
                // A completion in the read cycle keeps the flag set.
                if (done) begin
                    tflag_q <= 1'b1;                       // RQ4
                end else if (r_rxbuf) begin
                    tflag_q <= 1'b0;                       // RQ6
                end
                if (o_set) begin
                    oflag_q <= 1'b1;                       // RQ10
                end else if (w_stat & ~wd[`SPIRQ_B_OFLAG]) begin
                    oflag_q <= 1'b0;                       // RQ13
                end
            end
            if (done) begin
                rxbuf_q <= rx_data;
            end
        end
    end

    // Core side: flags, masks, global mask and vector register.
    always @(posedge aclk) begin
        if (!aresetn) begin
            ifr_q          <= 6'h00;
            imr_q          <= 6'h00;
            gmask_q        <= `SPIRQ_GMASK_RST;
            vect_q         <= 16'h0000;
            core_ack       <= 1'b0;
            core_ack_level <= 2'b00;
        end else if (ce) begin
            ifr_q    <= ifr_d;
            core_ack <= ack;
            if (w_imr) begin
                imr_q <= wd[5:0];
            end
            // The acknowledge sets the global mask, as entering a routine.
            if (ack) begin
                gmask_q        <= 1'b1;
                core_ack_level <= ack5 ? 2'b01 : 2'b00;
                vect_q         <= found ? voff(win) : 16'h0000; // RQ18
            end else if (w_gmask) begin
                gmask_q <= wd[0];
            end
        end
    end

    // Port request pulse, one per fresh enabled event.
    always @(posedge aclk) begin
        if (!aresetn) begin
            serial_port_irq <= 1'b0;
        end else if (ce) begin
            serial_port_irq <= port_req;                   // RQ23 RQ24
        end
    end

    // Read data mux.
    // The mux follows the read address; its value is stored at the taking edge.
    reg [31:0] rd_d;
    always @* begin
        rd_d = 32'h0000_0000;
        case (s_axi_araddr)
            `SPIRQ_A_CTRL: begin
                rd_d[`SPIRQ_B_TIE]  = tie_q;
                rd_d[`SPIRQ_B_OIE]  = oie_q;
                rd_d[`SPIRQ_B_PRIO] = prio_q;
            end
            `SPIRQ_A_STAT: begin
                rd_d[`SPIRQ_B_TFLAG] = tflag_q;
                rd_d[`SPIRQ_B_OFLAG] = oflag_q;
            end
            `SPIRQ_A_CHAR:  rd_d[`SPIRQ_B_SRST] = srst_q;
            `SPIRQ_A_RXBUF: rd_d[7:0]  = rxbuf_q;
            `SPIRQ_A_VECT:  rd_d[15:0] = vect_q;          // RQ22
            `SPIRQ_A_IFLAG: rd_d[5:0]  = ifr_q;
            `SPIRQ_A_IMASK: rd_d[5:0]  = imr_q;
            `SPIRQ_A_GMASK: rd_d[0]    = gmask_q;
            default:        rd_d       = 32'h0000_0000;
        endcase
    end

    // Bus responses; each stays until its ready is seen.
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `SPIRQ_OKAY;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp  <= `SPIRQ_OKAY;
            s_axi_rdata  <= 32'h0000_0000;
        end else if (ce) begin
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= mapped(s_axi_awaddr) ? `SPIRQ_OKAY : `SPIRQ_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (rd_go) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_d;
                s_axi_rresp  <= mapped(s_axi_araddr) ? `SPIRQ_OKAY : `SPIRQ_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule

// file: tb/spirq_chk_sva.sv
`timescale 1ns/1ps
// Ties the block's pulses and bus answers to their causes at the ports.
module spirq_chk (
    input wire        aclk,
    input wire        aresetn,
    input wire        ce,
    input wire        s_axi_awvalid,
    input wire        s_axi_awready,
    input wire        s_axi_wvalid,
    input wire        s_axi_wready,
    input wire [1:0]  s_axi_bresp,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready,
    input wire        char_done,
    input wire        serial_port_irq,
    input wire        core_ack,
    input wire [1:0]  core_ack_level
);
    // One clock domain, so clock and reset are given once.
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // A port request needs a character finished one edge earlier.
    AST_IRQ_CAUSE: assert property (serial_port_irq |-> $past(char_done) && $past(ce))
        else $error("port request without a character");
    // An acknowledge masks the core, so it never lasts two cycles.
    AST_ACK_PULSE: assert property (core_ack |=> !core_ack)
        else $error("acknowledge held");
    // The level moves only with an acknowledge and names level one or five.
    AST_ACK_LEVEL: assert property ((core_ack_level < 2'h2) && (core_ack || $stable(core_ack_level)))
        else $error("acknowledge level wrong");
    // Address and data are taken together, never one alone.
    AST_AW_PAIR: assert property (s_axi_awready |-> s_axi_wready && s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid)
        else $error("write channels taken apart");
    AST_WR_ANSWER: assert property (s_axi_awvalid && s_axi_awready |=> s_axi_bvalid)
        else $error("write answer late");
    AST_RD_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    // An answer stands unchanged until the master takes it.
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped");
endmodule
bind spirq_route spirq_chk chk (
    .aclk, .aresetn, .ce, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .char_done, .serial_port_irq, .core_ack,
    .core_ack_level
);

// file: tb/spirq_peer.sv
`timescale 1ns/1ps
// Stands in for the shift engine: one finished character per request.
module spirq_peer (
    input  wire       aclk,
    input  wire       go,
    input  wire [7:0] go_data,
    output reg        char_done,
    output reg  [7:0] rx_data
);
    reg [7:0] last_q;  // Last character handed over.
    initial begin
        char_done = 1'b0;
        rx_data = 8'h00;
        last_q = 8'h00;
    end
    // Outside the strobe the data shows the inverse, so stale sampling is caught.
    always @(posedge aclk) begin
        char_done <= go;
        rx_data <= go ? go_data : ~last_q;
        if (go) begin
            last_q <= go_data;
        end
    end
endmodule

// file: tb/test_serial_port_interrupt_routing.sv
`timescale 1ns/1ps
`include "spirq_defines.vh"
// Runs both levels against a small flag and vector model.
module test_serial_port_interrupt_routing;
    reg         aclk, aresetn, ce, async_level_five, go;
    reg  [7:0]  s_axi_awaddr, s_axi_araddr, go_data;
    reg  [31:0] s_axi_wdata, r;
    reg  [3:0]  s_axi_wstrb;
    reg         s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    reg  [6:0]  src, m;
    wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0]  s_axi_bresp, s_axi_rresp, core_ack_level;
    wire [31:0] s_axi_rdata;
    wire        char_done, serial_port_irq, core_ack;
    wire [7:0]  rx_data;
    integer     bad_count, check_count, seed, n, k, lv, i, acks, irqs, xirq;
    integer     tf, of, tie, oie, lrx;  // Model flags, enables, last character.
    reg  [15:0] vt [0:6];               // Vector offsets by source order.
    spirq_route dut (
        .aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .char_done, .rx_data,
        .external_pin_irq_one(src[0]), .external_pin_irq_two(src[1]),
        .external_pin_irq_three(src[2]), .async_receive_irq(src[4]),
        .async_transmit_irq(src[5]), .async_level_five, .realtime_tick_irq(src[6]),
        .serial_port_irq, .core_ack, .core_ack_level
    );
    spirq_peer peer (.aclk, .go, .go_data, .char_done, .rx_data);
    initial begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end
    // Counts output pulses; values read here are those before the edge.
    always @(posedge aclk) begin
        if (serial_port_irq === 1'b1) irqs = irqs + 1;
        if (core_ack === 1'b1) acks = acks + 1;
    end
    task report_and_stop;
        begin
            if (bad_count == 0 && check_count > 0) begin
                $display("All checks passed");
            end else begin
                $display("Checks failed");
            end
            $finish;
        end
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        begin
            check_count = check_count + 1;
            if (got !== exp) begin
                bad_count = bad_count + 1;
                $display("mismatch at %0t: got %h, expected %h", $time, got, exp);
            end
        end
    endtask
    // A wait that used its whole bound ends the run.
    task guard(input integer c);
        begin
            if (c >= 40) begin
                bad_count = bad_count + 1;
                $display("mismatch at %0t: handshake timed out", $time);
                report_and_stop;
            end
        end
    endtask
    // One access; each request holds until its ready, answers are taken at valid.
    task bus(input w, input [7:0] a, input [31:0] d, input [1:0] er = `SPIRQ_OKAY);
        begin
            if (w) begin
                s_axi_awaddr <= a;
                s_axi_wdata <= d;
                {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
                for (n = 0; n < 40 && s_axi_awready !== 1'b1; n = n + 1) @(posedge aclk);
                guard(n);
                {s_axi_awvalid, s_axi_wvalid} <= 2'h0;
                for (n = 0; n < 40 && s_axi_bvalid !== 1'b1; n = n + 1) @(posedge aclk);
                guard(n);
                s_axi_bready <= 1'b0;
                chk({30'h0, s_axi_bresp}, {30'h0, er});
            end else begin
                s_axi_araddr <= a;
                {s_axi_arvalid, s_axi_rready} <= 2'h3;
                for (n = 0; n < 40 && s_axi_arready !== 1'b1; n = n + 1) @(posedge aclk);
                guard(n);
                s_axi_arvalid <= 1'b0;
                for (n = 0; n < 40 && s_axi_rvalid !== 1'b1; n = n + 1) @(posedge aclk);
                guard(n);
                s_axi_rready <= 1'b0;
                chk(s_axi_rdata, d);
                chk({30'h0, s_axi_rresp}, {30'h0, er});
            end
            // One idle edge between accesses, so no strobe is set twice at one edge.
            @(posedge aclk);
        end
    endtask
    // Pulses sources for one cycle; bit 3 goes out as a finished character.
    task fire(input [6:0] s, input [7:0] d);
        begin
            src <= s & 7'h77;
            go <= s[3];
            go_data <= d;
            if (s[3]) begin
                if (tf == 1 && oie == 1 && of == 0) begin
                    of = 1;
                    xirq = xirq + 1;
                end else if (tf == 0 && tie == 1) begin
                    xirq = xirq + 1;
                end
                tf = 1;
                lrx = d;
            end
            @(posedge aclk);
            src <= 7'h00;
            go <= 1'b0;
            repeat (3) @(posedge aclk);
            chk(irqs, xirq);
        end
    endtask
    initial begin
        {bad_count, check_count, irqs, acks, xirq} = 0;
        seed = 32'h07F902FF;
        vt = '{`SPIRQ_V_EXT1, `SPIRQ_V_EXT2, `SPIRQ_V_EXT3, `SPIRQ_V_PORT,
               `SPIRQ_V_ARX, `SPIRQ_V_ATX, `SPIRQ_V_RT};
        {aresetn, async_level_five, go, src} = 10'h0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
        {s_axi_awaddr, s_axi_araddr, go_data, s_axi_wdata} = 56'h0;
        ce = 1'b1;
        s_axi_wstrb = 4'hF;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        bus(0, `SPIRQ_A_GMASK, 32'h1);
        bus(0, 8'h20, 32'h0, `SPIRQ_SLVERR);
        bus(1, 8'h20, 32'h0, `SPIRQ_SLVERR);
        // Each pass: port reset, random sources on one level, then flag rules.
        for (lv = 0; lv < 2; lv = lv + 1) begin
            async_level_five <= lv[0];
            bus(1, `SPIRQ_A_CHAR, 32'h80);
            bus(0, `SPIRQ_A_CTRL, 32'h0);
            bus(0, `SPIRQ_A_STAT, 32'h0);
            bus(1, `SPIRQ_A_CHAR, 32'h0);
            {tf, of, tie, oie} = {32'd0, 32'd0, 32'd1, 32'd1};
            bus(1, `SPIRQ_A_CTRL, 32'h11 | (lv << 6));
            bus(1, `SPIRQ_A_IFLAG, 32'h3F);
            bus(1, `SPIRQ_A_IMASK, 32'h1 << (lv * 4));
            r = $random(seed);
            m = (r[6:0] & (lv ? 7'h38 : 7'h7F)) | 7'h08;
            fire(m, r[15:8]);
            // Drain in priority order, one acknowledge per unmasking.
            for (i = 0; i < 7; i = i + 1) begin
                if (m[i]) begin
                    k = acks;
                    bus(1, `SPIRQ_A_GMASK, 32'h0);
                    for (n = 0; n < 40 && acks == k; n = n + 1) @(posedge aclk);
                    guard(n);
                    chk({30'h0, core_ack_level}, lv);
                    bus(0, `SPIRQ_A_VECT, {16'h0, vt[i]});
                end
            end
            fire(7'h08, r[23:16]);
            fire(7'h08, r[31:24]);
            bus(0, `SPIRQ_A_STAT, 32'hC0);
            bus(0, `SPIRQ_A_RXBUF, lrx);
            bus(1, `SPIRQ_A_STAT, 32'h80);
            bus(0, `SPIRQ_A_STAT, 32'h80);
            bus(1, `SPIRQ_A_STAT, 32'h0);
            bus(0, `SPIRQ_A_STAT, 32'h0);
            {tf, of, tie, oie} = 128'h0;
            bus(1, `SPIRQ_A_CTRL, lv << 6);
            fire(7'h08, r[7:0]);
            fire(7'h08, r[15:8]);
            bus(0, `SPIRQ_A_STAT, 32'h40);
            // A character that ends while the clock enable is low is lost.
            ce <= 1'b0;
            fire(7'h08, ~r[15:8]);
            ce <= 1'b1;
            lrx = r[15:8];
            bus(0, `SPIRQ_A_RXBUF, lrx);
        end
        report_and_stop;
    end
endmodule
